// File: hdl/pmt_pkg.sv
// Purpose: constants for the pulse measurement timer channel
// Assumes: AHB-Lite register access, 32-bit words
// Notes:   offsets are byte addresses of aligned words
package pmt_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // clock/mode/edge select
  localparam logic [7:0] OFS_IEN    = 8'h04;  // channel_interrupt_enable
  localparam logic [7:0] OFS_FLAGS  = 8'h08;  // channel_event_flags
  localparam logic [7:0] OFS_TCA    = 8'h0C;  // time_counter_primary
  localparam logic [7:0] OFS_EVC    = 8'h10;  // pulse_event_counter
  localparam logic [7:0] OFS_TCC    = 8'h14;  // time_counter_secondary
  localparam logic [7:0] OFS_CMP    = 8'h18;  // event_compare_value
  localparam logic [7:0] OFS_CLR    = 8'h1C;  // counter clear strobes
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SEC  = 3;   // secondary overflow / compare
  localparam int BIT_EVW  = 2;   // event wrap
  localparam int BIT_PRI  = 1;   // primary overflow
  localparam int BIT_CAP  = 0;   // capture
  localparam int CKS_LSB  = 5;   // clock select field low bit
  localparam int MD_LSB   = 2;   // mode field low bit
  localparam int EG_LSB   = 0;   // edge field low bit
  localparam int CNT_LSB  = 8;   // 24-bit count sits in 31:8
  // ----------------------------------------------------------------
  // reset and load values
  // ----------------------------------------------------------------
  localparam logic [23:0] TC_ZERO  = 24'h00_0000;
  localparam logic [23:0] TC_ONE   = 24'h00_0001;  // word 0000_0100
  localparam logic [23:0] TC_MAX   = 24'hFF_FFFF;
  localparam logic [15:0] EV_ZERO  = 16'h0000;
  localparam logic [15:0] EV_ONE   = 16'h0001;
  localparam logic [15:0] EV_MAX   = 16'hFFFF;
  localparam logic [15:0] CMP_RST  = 16'hFFFF;
  localparam logic [7:0]  BYTE_Z   = 8'h00;
  localparam logic [1:0]  EG_RISE  = 2'b01;
  localparam logic [1:0]  EG_FALL  = 2'b10;
  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PMT_EDGE_CNT = 3'b000,
    PMT_EDGE_INT = 3'b001,
    PMT_LEVEL    = 3'b010,
    PMT_RSVD     = 3'b011,
    PMT_PWM      = 3'b100,
    PMT_ROT      = 3'b101,
    PMT_UPDN     = 3'b110,
    PMT_QUAD     = 3'b111
  } pmt_mode_t;
endpackage

// File: hdl/pmt_channel.sv
// Purpose: one pulse measurement timer channel with AHB-Lite registers
// Assumes: clock buses are same-domain pulses; pulse inputs come from outside, async
// Notes:   counters, flags, enables and combined interrupt requests
//
// Operation
// - bit 3 enable gates secondary flag
// - bit 2 enable gates event wrap flag
// - bit 1 enable gates primary flag
// - bit 0 enable gates capture request
// - overflow request ORs three enabled flags
// - flags byte, bits 7..4 read zero
// - flag cleared by 0 after read 1
// - bit 3: C wrap or compare
// - bit 2: event counter wraps either way
// - bit 1: counter A wraps to zero
// - bit 0: capture; DMA view read clears
// - flags reset to zero
// - counter A counts selected bus, 31:8
// - A clear on count edge loads one
// - counters reset to zero
// - 16-bit up/down event counter on inputs
// - event clear on up-count edge loads one
// - single-input modes use selected edge
// - up/down: both edges, second sets direction
// - quad mode: all edges of both
// - C counts only PWM and rotation
// - C event clear on its clock, loads one
// - 3-bit clock select, codes 0..5
// - mode field decode
`timescale 1ns/100ps
`default_nettype none
module pmt_channel
  import pmt_pkg::*;
#(
  parameter int         NUM_BUS    = 6,     // clock buses
  parameter bit         UPDN_HI_UP = 1'b0   // second input high counts up
)(
  // clock, reset, enable
  input  wire logic               CORE_CLK_IN,
  input  wire logic               RST_IN,
  input  wire logic               CLK_EN_IN,
  // ahb-lite slave
  input  wire logic               HSEL_IN,
  input  wire logic [7:0]         HADDR_IN,
  input  wire logic [1:0]         HTRANS_IN,
  input  wire logic               HWRITE_IN,
  input  wire logic [2:0]         HSIZE_IN,
  input  wire logic               HREADY_IN,
  input  wire logic [31:0]        HWDATA_IN,
  output logic      [31:0]        HRDATA_OUT,
  output logic                    HREADYOUT_OUT,
  output logic                    HRESP_OUT,
  // counter clock buses (pulses, same clock domain)
  input  wire logic [NUM_BUS-1:0] CLK_BUS_IN,
  // external pulse pins
  input  wire logic               PULSE_INPUT_FIRST_IN,
  input  wire logic               PULSE_INPUT_SECOND_IN,
  // events from the rest of the channel
  input  wire logic               CAPTURE_IN,
  input  wire logic               DMA_VIEW_READ_IN,
  input  wire logic               SEC_CLEAR_EVT_IN,
  // interrupt requests
  output logic                    OVF_IRQ_OUT,
  output logic                    CAP_IRQ_OUT
);
  // elaboration check: the select field and bus vector must agree
  if (NUM_BUS != 6)
  begin : g_bus_check
    $error("pmt_channel: six clock buses required");
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_r;            // clock / mode / edge select
  logic [3:0]  ien_r;             // channel_interrupt_enable
  logic [3:0]  flags_r;           // channel_event_flags
  logic [3:0]  seen_one_r;        // flag read as 1 since last write
  logic [23:0] tca_r;             // time_counter_primary
  logic [15:0] evc_r;             // pulse_event_counter
  logic [23:0] tcc_r;             // time_counter_secondary
  logic [15:0] cmp_r;             // event_compare_value
  logic        sec_clr_pend_r;    // C clear waiting for its tick
  // bus pipeline
  logic        dp_wr_r;           // data phase write
  logic [7:0]  dp_addr_r;         // data phase address
  // field views
  logic [2:0]  cks;               // counter_clock_select
  pmt_mode_t   mode;              // channel_mode_select
  logic [1:0]  egs;               // edge_sense_select
  assign cks  = ctrl_r[CKS_LSB +: 3];
  assign mode = pmt_mode_t'(ctrl_r[MD_LSB +: 3]);
  assign egs  = ctrl_r[EG_LSB +: 2];
  // ----------------------------------------------------------------
  // pin synchronisers, three stages
  // ----------------------------------------------------------------
  logic [2:0] sa_r;               // first input stages
  logic [2:0] sb_r;               // second input stages
  logic       la_r;               // accepted first level
  logic       lb_r;               // accepted second level
  // stage 0 only feeds stage 1; a change counts when 1 and 2 agree
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      sa_r <= 3'b000;
      sb_r <= 3'b000;
      la_r <= 1'b0;
      lb_r <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      sa_r <= {sa_r[1:0], PULSE_INPUT_FIRST_IN};
      sb_r <= {sb_r[1:0], PULSE_INPUT_SECOND_IN};
      if (sa_r[1] == sa_r[2]) la_r <= sa_r[2];
      if (sb_r[1] == sb_r[2]) lb_r <= sb_r[2];
    end
  end
  // edge detection on accepted levels
  logic a_rise, a_fall, b_rise, b_fall, a_any, b_any;
  assign a_rise = CLK_EN_IN && (sa_r[1] == sa_r[2]) && sa_r[2] && !la_r;
  assign a_fall = CLK_EN_IN && (sa_r[1] == sa_r[2]) && !sa_r[2] && la_r;
  assign b_rise = CLK_EN_IN && (sb_r[1] == sb_r[2]) && sb_r[2] && !lb_r;
  assign b_fall = CLK_EN_IN && (sb_r[1] == sb_r[2]) && !sb_r[2] && lb_r;
  assign a_any  = a_rise || a_fall;
  assign b_any  = b_rise || b_fall;
  // ----------------------------------------------------------------
  // event count decision
  // ----------------------------------------------------------------
  logic ev_inc, ev_dec, a_sel_edge;
  // selected edge of first input; both edges only legal in some modes
  assign a_sel_edge = (egs[0] && a_rise) || (egs[1] && a_fall);
  always_comb
  begin
    ev_inc = 1'b0;
    ev_dec = 1'b0;
    case (mode)
      PMT_EDGE_CNT, PMT_EDGE_INT, PMT_LEVEL, PMT_PWM, PMT_ROT:
        ev_inc = a_sel_edge;
      PMT_UPDN:
      begin
        // direction from current second level, polarity set by parameter
        ev_inc = a_any && (lb_r == UPDN_HI_UP);
        ev_dec = a_any && (lb_r != UPDN_HI_UP);
      end
      PMT_QUAD:
      begin
        // quadrature: direction from the other phase level
        ev_inc = (a_any && (sa_r[2] != lb_r)) ||
                 (b_any && (sb_r[2] == la_r));
        ev_dec = (a_any && (sa_r[2] == lb_r)) ||
                 (b_any && (sb_r[2] != la_r));
      end
      default: ev_inc = 1'b0;   // reserved mode holds the counter
    endcase
  end
  // ----------------------------------------------------------------
  // bus access decode
  // ----------------------------------------------------------------
  logic ap_valid;                 // address phase accepted
  assign ap_valid = HSEL_IN && HREADY_IN && HTRANS_IN[1] && CLK_EN_IN;
  logic wr_now;                   // write data on bus this cycle
  assign wr_now = dp_wr_r && CLK_EN_IN;
  // single-cycle data phase, always OKAY
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= BYTE_Z;
    end
    else if (CLK_EN_IN)
    begin
      dp_wr_r   <= ap_valid && HWRITE_IN;
      dp_addr_r <= HADDR_IN;
    end
  end
  // write strobes per register
  logic w_ctrl, w_ien, w_flags, w_tca, w_evc, w_tcc, w_cmp, w_clr;
  assign w_ctrl  = wr_now && dp_addr_r == OFS_CTRL;
  assign w_ien   = wr_now && dp_addr_r == OFS_IEN;
  assign w_flags = wr_now && dp_addr_r == OFS_FLAGS;
  assign w_tca   = wr_now && dp_addr_r == OFS_TCA;
  assign w_evc   = wr_now && dp_addr_r == OFS_EVC;
  assign w_tcc   = wr_now && dp_addr_r == OFS_TCC;
  assign w_cmp   = wr_now && dp_addr_r == OFS_CMP;
  assign w_clr   = wr_now && dp_addr_r == OFS_CLR;
  // ----------------------------------------------------------------
  // control, enable and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      ctrl_r <= BYTE_Z;
      ien_r  <= 4'h0;
      cmp_r  <= CMP_RST;
    end
    else if (CLK_EN_IN)
    begin
      if (w_ctrl) ctrl_r <= HWDATA_IN[7:0];
      if (w_ien)  ien_r  <= HWDATA_IN[3:0];
      if (w_cmp)  cmp_r  <= HWDATA_IN[15:0];
    end
  end
  // ----------------------------------------------------------------
  // shared count tick from the selected clock bus
  // ----------------------------------------------------------------
  logic tick;
  // reserved codes 110/111 pick no bus; time counters then stand still
  assign tick = CLK_EN_IN && (cks < 3'(NUM_BUS)) && CLK_BUS_IN[cks];
  // ----------------------------------------------------------------
  // time counter A
  // ----------------------------------------------------------------
  logic clr_a, clr_e;             // software clear strobes
  assign clr_a = w_clr && HWDATA_IN[0];
  assign clr_e = w_clr && HWDATA_IN[1];
  logic a_wrap;
  assign a_wrap = tick && !clr_a && !w_tca && tca_r == TC_MAX;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      tca_r <= TC_ZERO;
    else if (CLK_EN_IN)
    begin
      if (clr_a)
        tca_r <= tick ? TC_ONE : TC_ZERO;
      else if (w_tca)
        tca_r <= HWDATA_IN[CNT_LSB +: 24];
      else if (tick)
        tca_r <= tca_r + TC_ONE;
    end
  end
  // ----------------------------------------------------------------
  // event counter
  // ----------------------------------------------------------------
  logic e_wrap;
  assign e_wrap = !clr_e && !w_evc &&
                  ((ev_inc && !ev_dec && evc_r == EV_MAX) ||
                   (ev_dec && !ev_inc && evc_r == EV_ZERO));
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      evc_r <= EV_ZERO;
    else if (CLK_EN_IN)
    begin
      if (clr_e)
        evc_r <= (ev_inc && !ev_dec) ? EV_ONE : EV_ZERO;
      else if (w_evc)
        evc_r <= HWDATA_IN[15:0];
      else if (ev_inc && !ev_dec)
        evc_r <= evc_r + EV_ONE;
      else if (ev_dec && !ev_inc)
        evc_r <= evc_r - EV_ONE;
    end
  end
  // ----------------------------------------------------------------
  // time counter C
  // ----------------------------------------------------------------
  logic c_run, c_wrap, c_match;
  assign c_run   = (mode == PMT_PWM) || (mode == PMT_ROT);
  assign c_wrap  = tick && c_run && !sec_clr_pend_r && !w_tcc &&
                   tcc_r == TC_MAX && mode == PMT_PWM;
  // compare against value with eight zero low bits, i.e. its 24-bit view
  assign c_match = c_run && mode == PMT_ROT &&
                   tcc_r == {cmp_r, BYTE_Z};
  logic c_match_d_r;              // match edge so flag sets once
  // external clear requests wait for the next count tick
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      tcc_r          <= TC_ZERO;
      sec_clr_pend_r <= 1'b0;
      c_match_d_r    <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      c_match_d_r <= c_match;
      if (w_tcc)
        tcc_r <= HWDATA_IN[CNT_LSB +: 24];
      else if (tick && c_run && sec_clr_pend_r)
        tcc_r <= TC_ONE;
      else if (tick && c_run)
        tcc_r <= tcc_r + TC_ONE;
      if (tick && c_run)
        sec_clr_pend_r <= 1'b0;
      if (c_run && SEC_CLEAR_EVT_IN)
        sec_clr_pend_r <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  logic [3:0] set_v, clr_v;
  assign set_v[BIT_SEC] = c_wrap || (c_match && !c_match_d_r);
  assign set_v[BIT_EVW] = e_wrap;
  assign set_v[BIT_PRI] = a_wrap;
  assign set_v[BIT_CAP] = CAPTURE_IN && CLK_EN_IN;
  // clear only where 0 is written after a read of 1; writing 1 ignored
  assign clr_v = w_flags ? (~HWDATA_IN[3:0] & seen_one_r) : 4'h0;
  logic rd_flags;                 // flags read in its address phase
  // marks follow the very value that is latched onto hrdata
  assign rd_flags = ap_valid && !HWRITE_IN && HADDR_IN == OFS_FLAGS;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_flag
      logic dma_clr;
      assign dma_clr = (gi == BIT_CAP) && DMA_VIEW_READ_IN;
      always_ff @(posedge CORE_CLK_IN)
      begin
        if (RST_IN)
        begin
          flags_r[gi]    <= 1'b0;
          seen_one_r[gi] <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
          // set wins over any clear in the same cycle
          if (set_v[gi])
            flags_r[gi] <= 1'b1;
          else if (clr_v[gi] || dma_clr)
            flags_r[gi] <= 1'b0;
          if (rd_flags && flags_r[gi])
            seen_one_r[gi] <= 1'b1;   // a 1 handed out stays clearable
          else if (w_flags || dma_clr)
            seen_one_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  assign OVF_IRQ_OUT = (flags_r[BIT_SEC] && ien_r[BIT_SEC]) ||
                       (flags_r[BIT_EVW] && ien_r[BIT_EVW]) ||
                       (flags_r[BIT_PRI] && ien_r[BIT_PRI]);
  assign CAP_IRQ_OUT = flags_r[BIT_CAP] && ien_r[BIT_CAP];
  // ----------------------------------------------------------------
  // read data, registered in the address phase
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (HADDR_IN)
      OFS_CTRL:  rd_mux = {24'h00_0000, ctrl_r};
      OFS_IEN:   rd_mux = {28'h000_0000, ien_r};
      OFS_FLAGS: rd_mux = {28'h000_0000, flags_r};
      OFS_TCA:   rd_mux = {tca_r, BYTE_Z};
      OFS_EVC:   rd_mux = {16'h0000, evc_r};
      OFS_TCC:   rd_mux = {tcc_r, BYTE_Z};
      OFS_CMP:   rd_mux = {16'h0000, cmp_r};
      default:   rd_mux = 32'h0000_0000;   // unmapped reads zero
    endcase
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      HRDATA_OUT <= 32'h0000_0000;
    else if (CLK_EN_IN && ap_valid && !HWRITE_IN)
      HRDATA_OUT <= rd_mux;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ovf_irq_or: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    OVF_IRQ_OUT == |(flags_r[3:1] & ien_r[3:1]))
    else $error("overflow request mismatch");
  a_cap_irq_gate: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !ien_r[BIT_CAP] |-> !CAP_IRQ_OUT)
    else $error("capture request not gated");
  a_flag_set_wins: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && set_v[BIT_PRI] |=> flags_r[BIT_PRI])
    else $error("primary flag lost");
  a_a_wrap_flag: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && a_wrap |=> tca_r == TC_ZERO && flags_r[BIT_PRI])
    else $error("counter A wrap wrong");
  a_flag_no_sw_set: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !flags_r[BIT_EVW] && !set_v[BIT_EVW] |=> !flags_r[BIT_EVW])
    else $error("event flag set without cause");
  a_c_hold: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    !c_run && !w_tcc |=> $stable(tcc_r))
    else $error("counter C moved outside its modes");
  a_evc_wrap_flag: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && e_wrap |=> flags_r[BIT_EVW])
    else $error("event wrap flag missing");
  a_a_clr_tick: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    clr_a && tick |=> tca_r == TC_ONE)
    else $error("counter A clear value wrong");
endmodule
`default_nettype wire

// File: bench/pmt_pulse_src.sv
// Purpose: far-side model of the two external pulse pins
// Assumes: one clock; pins move just after a rising edge
// Notes:   clean levels only, no noise and no glitches
`timescale 1ns/100ps
`default_nettype none
module pmt_pulse_src (
  // clock and step requests
  input  wire logic clk_in,
  input  wire logic step_a_in,
  input  wire logic step_b_in,
  // pulse pins
  output logic      pin_a_out,
  output logic      pin_b_out
);
  // both pins idle low
  initial
  begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // one flip per request; b level doubles as up/down direction
  always @(posedge clk_in)
  begin
    if (step_a_in) pin_a_out <= ~pin_a_out;
    if (step_b_in) pin_b_out <= ~pin_b_out;
  end
endmodule
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for the pulse measurement channel
// Assumes: zero-wait ahb-lite slave, pins synchronised in the channel
// Notes:   expected values come from a small integer model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pmt_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic        clk, rst, hwrite, cap, dma, sta, stb, hrdy, hresp, ovf, capq, pa, pb, secq;
  logic [1:0]  htrans;
  logic [7:0]  haddr;
  logic [5:0]  cbus;
  logic [31:0] hwdata, hrdata, d;
  int          err_total, compares, m_flags, m_evc, i;
  pmt_channel u_pmt_channel (.CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .HSEL_IN(1'b1),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HREADY_IN(hrdy),
    .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .CLK_BUS_IN(cbus), .PULSE_INPUT_FIRST_IN(pa), .PULSE_INPUT_SECOND_IN(pb), .CAPTURE_IN(cap),
    .DMA_VIEW_READ_IN(dma), .SEC_CLEAR_EVT_IN(secq), .OVF_IRQ_OUT(ovf), .CAP_IRQ_OUT(capq));
  pmt_pulse_src u_pmt_pulse_src (.clk_in(clk), .step_a_in(sta), .step_b_in(stb),
    .pin_a_out(pa), .pin_b_out(pb));
  // 50 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("counts: compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (hrdy === 1'b1) return;
    end
    err_total++;
    results;
  endtask
  // one single word transfer, read data left in d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    d = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(d, exp);
  endtask
  // irq levels are looked at once the edge has settled
  task automatic irq(input logic eo, input logic ec);
    #1;
    chk({30'h0, ovf, capq}, {30'h0, eo, ec});
  endtask
  // pin steps; the synchroniser needs a few cycles
  task automatic step(input logic a, input logic b);
    @(posedge clk);
    sta <= a;
    stb <= b;
    @(posedge clk);
    sta <= 1'b0;
    stb <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // one-cycle pulse on the chosen clock buses
  task automatic tk(input logic [5:0] b);
    @(posedge clk);
    cbus <= b;
    @(posedge clk);
    cbus <= 6'h00;
  endtask
  // model of one event count, with wrap flag
  task automatic ev(input bit up);
    m_evc = up ? m_evc + 1 : m_evc - 1;
    if (m_evc > 65535 || m_evc < 0) m_flags |= 4;
    m_evc &= 32'h0000_FFFF;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, htrans, haddr, hwrite, hwdata, cbus, cap, dma, sta, stb, secq} = '0;
    rst = 1'b1;
    {err_total, compares, m_flags, m_evc} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(32'h971e));
    rdc(OFS_FLAGS, 0);
    rdc(OFS_TCA, 0);
    rdc(OFS_EVC, 0);
    rdc(OFS_TCC, 0);
    rdc(8'h20, 0);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("test reset done");
    bus(1'b1, OFS_CTRL, 0);
    bus(1'b1, OFS_TCA, 32'hFFFF_FF00);
    @(posedge clk) cbus <= 6'h01;
    @(posedge clk) cbus <= 6'h00;
    m_flags = 1 << BIT_PRI;
    rdc(OFS_TCA, 0);
    rdc(OFS_FLAGS, m_flags);
    rdc(OFS_TCC, 0);
    irq(0, 0);
    bus(1'b1, OFS_IEN, 32'h0000_0002);
    irq(1, 0);
    bus(1'b1, OFS_FLAGS, 32'h0000_00FF);
    rdc(OFS_FLAGS, m_flags);
    bus(1'b1, OFS_FLAGS, 0);
    m_flags = 0;
    rdc(OFS_FLAGS, 0);
    irq(0, 0);
    @(posedge clk) cbus <= 6'h01;
    bus(1'b1, OFS_CLR, 1);
    cbus <= 6'h00;
    rdc(OFS_TCA, 32'h0000_0100);
    bus(1'b1, OFS_CLR, 1);
    rdc(OFS_TCA, 0);
    $display("test primary counter done");
    bus(1'b1, OFS_CTRL, 32'h0000_001B);
    step(0, 1);
    step(1, 0);
    ev(0);
    rdc(OFS_EVC, m_evc);
    rdc(OFS_FLAGS, m_flags);
    step(0, 1);
    for (i = 0; i < 2; i++)
    begin
      step(1, 0);
      ev(1);
    end
    rdc(OFS_EVC, m_evc);
    bus(1'b1, OFS_IEN, 32'h0000_0004);
    irq(1, 0);
    bus(1'b1, OFS_CTRL, 32'h0000_001F);
    for (i = 0; i < 2; i++)
    begin
      step(0, 1);
      step(1, 0);
      ev(1);
      ev(1);
    end
    rdc(OFS_EVC, m_evc);
    $display("test event counter done");
    @(posedge clk) cap <= 1'b1;
    @(posedge clk) cap <= 1'b0;
    m_flags |= 1;
    rdc(OFS_FLAGS, m_flags);
    bus(1'b1, OFS_IEN, 32'h0000_0001);
    irq(0, 1);
    @(posedge clk) dma <= 1'b1;
    @(posedge clk) dma <= 1'b0;
    m_flags -= 1;
    rdc(OFS_FLAGS, m_flags);
    irq(0, 0);
    $display("test capture done");
    bus(1'b1, OFS_CTRL, 32'h0000_0071);
    bus(1'b1, OFS_TCC, 32'hFFFF_FF00);
    tk(6'h37);
    rdc(OFS_TCC, 32'hFFFF_FF00);
    tk(6'h08);
    m_flags |= 1 << BIT_SEC;
    rdc(OFS_TCC, 0);
    rdc(OFS_FLAGS, m_flags);
    bus(1'b1, OFS_IEN, 32'h0000_0008);
    irq(1, 0);
    @(posedge clk) secq <= 1'b1;
    @(posedge clk) secq <= 1'b0;
    tk(6'h08);
    rdc(OFS_TCC, 32'h0000_0100);
    bus(1'b1, OFS_FLAGS, 0);
    m_flags = 0;
    bus(1'b1, OFS_CTRL, 32'h0000_0075);
    bus(1'b1, OFS_TCC, 32'h0000_FF00);
    bus(1'b1, OFS_CMP, 32'h0000_0001);
    rdc(OFS_FLAGS, m_flags);
    tk(6'h08);
    m_flags |= 1 << BIT_SEC;
    rdc(OFS_FLAGS, m_flags);
    rdc(OFS_TCA, 32'h0000_0300);
    $display("test secondary counter done");
    for (i = 0; i < 4; i++)
    begin
      m_evc = $urandom & 32'h0000_FFFF;
      bus(1'b1, OFS_EVC, m_evc);
      rdc(OFS_EVC, m_evc);
    end
    bus(1'b1, OFS_CLR, 32'h0000_0002);
    rdc(OFS_EVC, 0);
    $display("test random readback done");
    results;
  end
endmodule
`default_nettype wire
